// File: design/hbsc_consts.vh
// constants of the half-bridge serial control block
`ifndef HBSC_CONSTS_VH
`define HBSC_CONSTS_VH
`define HBSC_WORD_W 16
`define HBSC_CNT_W 5
`define HBSC_CTL_CLEAR 0
`define HBSC_CTL_SW_LO 1
`define HBSC_CTL_SW_HI 6
`define HBSC_CTL_OCS 13
`define HBSC_ST_PREWARN 0
`define HBSC_ST_SHORT 13
`define HBSC_ST_OPEN 14
`define HBSC_ST_SUPPLY 15
`define HBSC_CTL_RESET 16'h2000
`define HBSC_CLK_MHZ 125
`define HBSC_UV_DELAY_NS 8000
`define HBSC_OL_DELAY_NS 8000
`define HBSC_SD_DELAY_NS 4000
`define HBSC_UV_CYCLES ((`HBSC_UV_DELAY_NS * `HBSC_CLK_MHZ + 999) / 1000)
`define HBSC_OL_CYCLES ((`HBSC_OL_DELAY_NS * `HBSC_CLK_MHZ + 999) / 1000)
`define HBSC_SD_CYCLES ((`HBSC_SD_DELAY_NS * `HBSC_CLK_MHZ + 999) / 1000)
`define HBSC_DLY_W 12
`endif

// File: design/hbsc_sync.v
// three-stage synchroniser for one pin input
`timescale 1ns/1ps
module hbsc_sync (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire pin_i,
    input wire rst_val_i,
    output reg level_o
);
    reg s1;
    reg s2;
    reg s3;
    reg lvl;
    // stages hold pin xor idle level, so reset reads as the idle level
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
        end else begin
            s1 <= pin_i ^ rst_val_i;
            s2 <= s1;
            s3 <= s2;
            // change counts once second and third stage agree
            if (s2 == s3)
                lvl <= s3;
        end
    end
    always @* begin
        level_o = lvl ^ rst_val_i;
    end
endmodule // hbsc_sync

// File: design/hbsc_delay.v
// qualifies a condition that must persist for a number of cycles
`timescale 1ns/1ps
`include "hbsc_consts.vh"
module hbsc_delay #(
    parameter [`HBSC_DLY_W-1:0] CYCLES = 12'h0001
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire cond_i,
    output reg hit_o
);
    reg [`HBSC_DLY_W-1:0] cnt;
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 12'h0000;
            hit_o <= 1'b0;
        end else if (!cond_i) begin
            cnt <= 12'h0000;
            hit_o <= 1'b0;
        end else if (cnt >= CYCLES) begin
            hit_o <= 1'b1;
        end else begin
            cnt <= cnt + 12'h0001;
        end
    end
endmodule // hbsc_delay

// File: design/hbsc_top.v
// serial control and diagnostics of a triple half-bridge driver
`timescale 1ns/1ps
`include "hbsc_consts.vh"
module hbsc_top (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire chip_select_b_i,
    input wire serial_clk_i,
    input wire serial_in_i,
    input wire standby_select_b_i,
    input wire undervoltage_i,
    input wire [5:0] open_load_i,
    input wire [5:0] overcurrent_i,
    input wire temp_prewarning_i,
    input wire overtemp_i,
    output reg serial_out_o,
    output reg serial_out_oe_o,
    output reg [5:0] switch_on_o,
    output reg [5:0] switch_tristate_o,
    output reg overcurrent_shutdown_en_o
);
    localparam integer UV_INT = `HBSC_UV_CYCLES;
    localparam integer OL_INT = `HBSC_OL_CYCLES;
    localparam integer SD_INT = `HBSC_SD_CYCLES;
    localparam [`HBSC_DLY_W-1:0] UV_CYC = UV_INT[`HBSC_DLY_W-1:0];
    localparam [`HBSC_DLY_W-1:0] OL_CYC = OL_INT[`HBSC_DLY_W-1:0];
    localparam [`HBSC_DLY_W-1:0] SD_CYC = SD_INT[`HBSC_DLY_W-1:0];

    wire cs_b;
    wire sclk;
    wire sdin;
    wire stby_b;
    hbsc_sync u_sync_cs (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(chip_select_b_i),
        .rst_val_i(1'b1),
        .level_o(cs_b)
    );
    hbsc_sync u_sync_clk (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(serial_clk_i),
        .rst_val_i(1'b0),
        .level_o(sclk)
    );
    hbsc_sync u_sync_din (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(serial_in_i),
        .rst_val_i(1'b0),
        .level_o(sdin)
    );
    hbsc_sync u_sync_stby (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(standby_select_b_i),
        .rst_val_i(1'b0),
        .level_o(stby_b)
    );

    // cs synchroniser resets to its idle high, so no false frame start
    reg cs_prev;
    reg sclk_prev;
    reg stby_prev;
    wire cs_q = cs_b;
    wire cs_fall = cs_prev & ~cs_q;
    wire cs_rise = ~cs_prev & cs_q;
    wire sclk_fall = sclk_prev & ~sclk & ~cs_q;
    wire sclk_rise = ~sclk_prev & sclk & ~cs_q;
    wire stby_rise = ~stby_prev & stby_b;

    // condition detectors, one per delayed event
    wire uv_hit;
    wire ol_any = |(open_load_i & switch_on_o);
    wire ol_hit;
    wire [5:0] sd_hit;
    hbsc_delay #(.CYCLES(UV_CYC)) u_uv (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .cond_i(undervoltage_i & stby_b),
        .hit_o(uv_hit)
    );
    hbsc_delay #(.CYCLES(OL_CYC)) u_ol (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .cond_i(ol_any & stby_b),
        .hit_o(ol_hit)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sd
            hbsc_delay #(.CYCLES(SD_CYC)) u_sd (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .cond_i(overcurrent_i[gi] & stby_b),
                .hit_o(sd_hit[gi])
            );
        end
    endgenerate

    reg [15:0] shreg;
    reg [4:0] bit_cnt;
    reg [15:0] ctl;
    reg [5:0] tripped;
    reg therm_latch;
    reg flag_short;
    reg flag_open;
    reg flag_supply;
    reg [5:0] next_sw;

    wire [5:0] cmd_sw = ctl[`HBSC_CTL_SW_HI:`HBSC_CTL_SW_LO];
    wire ocs_en = ctl[`HBSC_CTL_OCS];
    wire do_exec = cs_rise & (bit_cnt == 5'h10);
    wire clr = do_exec & shreg[`HBSC_CTL_CLEAR];
    wire trip_now = ocs_en ? |sd_hit : 1'b0;

    // status word as seen by the host
    wire [15:0] status = {flag_supply, flag_open, flag_short, 6'h00,
        switch_on_o, temp_prewarning_i};

    always @* begin
        // undervoltage gates without latching; recovery re-enables
        next_sw = cmd_sw & ~tripped;
        if (uv_hit | therm_latch | overtemp_i | ~stby_b)
            next_sw = 6'h00;
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_prev <= 1'b1;
            sclk_prev <= 1'b0;
            stby_prev <= 1'b0;
        end else begin
            cs_prev <= cs_q;
            sclk_prev <= sclk;
            stby_prev <= stby_b;
        end
    end

    // serial shift path; load on select fall, shift per clock
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shreg <= 16'h0000;
            bit_cnt <= 5'h00;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            serial_out_oe_o <= ~cs_q;
            if (cs_fall) begin
                shreg <= status;
                bit_cnt <= 5'h00;
                serial_out_o <= status[`HBSC_ST_PREWARN];
            end else if (sclk_fall) begin
                // lsb leaves first, new bit enters the top
                shreg <= {sdin, shreg[15:1]};
                if (bit_cnt != 5'h10)
                    bit_cnt <= bit_cnt + 5'h01;
            end else if (sclk_rise) begin
                serial_out_o <= shreg[0];
            end
        end
    end

    // control register and sticky flags
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl <= `HBSC_CTL_RESET;
            tripped <= 6'h00;
            therm_latch <= 1'b0;
            flag_short <= 1'b0;
            flag_open <= 1'b0;
            flag_supply <= 1'b0;
        end else if (!stby_b || stby_rise) begin
            // standby clears status; its release re-runs power-on reset
            ctl <= `HBSC_CTL_RESET;
            tripped <= 6'h00;
            therm_latch <= 1'b0;
            flag_short <= 1'b0;
            flag_open <= 1'b0;
            flag_supply <= 1'b0;
        end else begin
            if (do_exec)
                ctl <= shreg;
            // set wins over a simultaneous clear
            if (uv_hit)
                flag_supply <= 1'b1;
            else if (clr)
                flag_supply <= 1'b0;
            if (ol_hit)
                flag_open <= 1'b1;
            else if (clr)
                flag_open <= 1'b0;
            if (|sd_hit)
                flag_short <= 1'b1;
            else if (clr)
                flag_short <= 1'b0;
            if (trip_now)
                tripped <= tripped | sd_hit;
            else if (clr)
                tripped <= 6'h00;
            if (overtemp_i)
                therm_latch <= 1'b1;
            else if (clr)
                therm_latch <= 1'b0;
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            switch_on_o <= 6'h00;
            switch_tristate_o <= 6'h3f;
            overcurrent_shutdown_en_o <= 1'b1;
        end else begin
            switch_on_o <= next_sw;
            switch_tristate_o <= stby_b ? 6'h00 : 6'h3f;
            overcurrent_shutdown_en_o <= ocs_en;
        end
    end
endmodule // hbsc_top

// File: sim/hbsc_properties.sv
// port assertions for hbsc_top
`timescale 1ns/1ps
module hbsc_chk (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire chip_select_b_i,
    input wire serial_clk_i,
    input wire standby_select_b_i,
    input wire undervoltage_i,
    input wire overtemp_i,
    input wire serial_out_o,
    input wire serial_out_oe_o,
    input wire [5:0] switch_on_o,
    input wire [5:0] switch_tristate_o,
    input wire overcurrent_shutdown_en_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // counts the undervoltage pin past the 1000-cycle qualifier
    logic [10:0] uv_cnt;
    always @(posedge core_clk_i or negedge rst_b_i)
        if (!rst_b_i) uv_cnt <= 11'h000;
        else if (!undervoltage_i) uv_cnt <= 11'h000;
        else if (uv_cnt != 11'h7ff) uv_cnt <= uv_cnt + 11'h001;
    sequence s_sel_fall;
        $fell(chip_select_b_i) ##1
            (!chip_select_b_i && standby_select_b_i)[*7];
    endsequence
    sequence s_idle;
        (chip_select_b_i && standby_select_b_i)[*8];
    endsequence
    property p_oe_on;
        s_sel_fall |-> serial_out_oe_o;
    endproperty
    property p_oe_off;
        s_idle |-> !serial_out_oe_o;
    endproperty
    property p_out_hold;
        (!chip_select_b_i && $stable(serial_clk_i)
            && $stable(chip_select_b_i))[*8] |-> $stable(serial_out_o);
    endproperty
    property p_ctl_hold;
        (!chip_select_b_i && standby_select_b_i)[*8]
            |-> $stable(overcurrent_shutdown_en_o);
    endproperty
    property p_rst_val;
        $rose(rst_b_i) |-> overcurrent_shutdown_en_o && switch_on_o == 6'h00;
    endproperty
    property p_uv_off;
        uv_cnt == 11'h3fc |-> switch_on_o == 6'h00;
    endproperty
    property p_ovt_off;
        overtemp_i[*8] |-> switch_on_o == 6'h00;
    endproperty
    property p_standby;
        (!standby_select_b_i)[*8]
            |-> switch_tristate_o == 6'h3f && switch_on_o == 6'h00;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout not on");
    a_oe_off: assert property (p_oe_off) else $error("dout on");
    a_out_hold: assert property (p_out_hold) else $error("dout moved");
    a_ctl_hold: assert property (p_ctl_hold) else $error("ctl early");
    a_rst_val: assert property (p_rst_val) else $error("bad reset");
    a_uv_off: assert property (p_uv_off) else $error("uv on");
    a_ovt_off: assert property (p_ovt_off) else $error("hot on");
    a_standby: assert property (p_standby) else $error("stby on");
endmodule // hbsc_chk

bind hbsc_top hbsc_chk u_hbsc_chk (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .chip_select_b_i(chip_select_b_i),
    .serial_clk_i(serial_clk_i), .standby_select_b_i(standby_select_b_i),
    .undervoltage_i(undervoltage_i), .overtemp_i(overtemp_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .switch_on_o(switch_on_o), .switch_tristate_o(switch_tristate_o),
    .overcurrent_shutdown_en_o(overcurrent_shutdown_en_o));

// File: sim/hbsc_host_model.sv
// behavioural serial bus master in the host's place
`timescale 1ns/1ps
module hbsc_host_model (
    input wire core_clk_i,
    input wire serial_out_i,
    input wire serial_out_oe_i,
    output reg chip_select_b_o,
    output reg serial_clk_o,
    output reg serial_in_o,
    output reg [15:0] rx_word_o,
    output reg rx_valid_o
);
    initial begin
        chip_select_b_o = 1'b1;
        serial_clk_o = 1'b0;
        serial_in_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_word_o = 16'h0000;
    end
    // 4 core cycles a half period: the 64 ns link clock
    task automatic half();
        repeat (4) @(negedge core_clk_i);
    endtask
    task automatic xfer(input logic [19:0] word, input int nbits);
        chip_select_b_o = 1'b0;
        repeat (3) half();
        for (int i = 0; i < nbits; i++) begin
            serial_in_o = word[i];
            serial_clk_o = 1'b1;
            half();
            serial_clk_o = 1'b0;
            half();
            // bit set up by this rising edge has settled by now
            if (i < 16) rx_word_o[i] = serial_out_oe_i ? serial_out_i : 1'bz;
        end
        // data line is driven back low before select rises
        serial_in_o = 1'b0;
        chip_select_b_o = 1'b1;
        if (nbits >= 16) begin
            rx_valid_o = 1'b1;
            @(negedge core_clk_i);
            rx_valid_o = 1'b0;
        end
    endtask
endmodule // hbsc_host_model

// File: sim/testbench.sv
// self-checking bench for hbsc_top
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
    logic clk = 0, rst_b = 0, stby_b = 1, uv = 0, pw = 0, ot = 0;
    logic [5:0] ol = 6'h00, oc = 6'h00;
    wire cs_b, sclk, din, dout, oe, ocs_en, rxv;
    wire [5:0] sw, tri_s;
    wire [15:0] rx;
    int error_cnt = 0, compares = 0, cyc = 0;
    logic [15:0] exp_q[$];
    logic [15:0] w, prev, exp_w;
    initial forever #4 clk = ~clk;
    hbsc_top u_hbsc_top (.core_clk_i(clk), .rst_b_i(rst_b),
        .chip_select_b_i(cs_b), .serial_clk_i(sclk), .serial_in_i(din),
        .standby_select_b_i(stby_b), .undervoltage_i(uv),
        .open_load_i(ol), .overcurrent_i(oc), .temp_prewarning_i(pw),
        .overtemp_i(ot), .serial_out_o(dout), .serial_out_oe_o(oe),
        .switch_on_o(sw), .switch_tristate_o(tri_s),
        .overcurrent_shutdown_en_o(ocs_en));
    hbsc_host_model u_hbsc_host_model (.core_clk_i(clk),
        .serial_out_i(dout), .serial_out_oe_i(oe), .chip_select_b_o(cs_b),
        .serial_clk_o(sclk), .serial_in_o(din), .rx_word_o(rx),
        .rx_valid_o(rxv));
    task summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    always @(posedge rxv) begin
        exp_w = exp_q.pop_front();
        `CHK("status", exp_w, rx)
    end
    function automatic logic [15:0] st(input logic [2:0] f,
            input logic [5:0] s);
        return {f, 6'h00, s, pw};
    endfunction
    task frame(input logic [19:0] v, input int n, input logic [15:0] e);
        if (n >= 16) exp_q.push_back(e);
        u_hbsc_host_model.xfer(v, n);
        repeat (12) @(negedge clk);
    endtask
    task hold(input int n, input logic [5:0] s);
        repeat (n) @(negedge clk);
        `CHK("switch", s, sw)
    endtask
    initial begin
        void'($urandom(94));
        repeat (4) @(negedge clk);
        rst_b = 1;
        repeat (8) @(negedge clk);
        `CHK("ocs", 1'b1, ocs_en)
        prev = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            w = $urandom;
            w[15] = 1'b0; // keeps clear of test patterns
            w[0] = 1'b0;
            pw = w[7];
            frame({4'h0, w}, 16, st(3'b000, prev[6:1]));
            `CHK("switch", w[6:1], sw)
            `CHK("ocs", w[13], ocs_en)
            prev = w;
        end
        frame(20'h0207e, 16, st(3'b000, prev[6:1]));
        frame(20'h00000, 8, 16'h0000);
        hold(1, 6'h3f);
        frame(20'h20545, 20, st(3'b000, 6'h3f));
        hold(1, 6'h2a);
        oc = 6'h02;
        hold(700, 6'h28);
        oc = 6'h00;
        frame(20'h02055, 16, st(3'b001, 6'h28));
        hold(1, 6'h2a);
        frame(20'h00054, 16, st(3'b000, 6'h2a));
        oc = 6'h02;
        hold(700, 6'h2a);
        oc = 6'h00;
        uv = 1;
        hold(1100, 6'h00);
        uv = 0;
        hold(20, 6'h2a);
        ol = 6'h08;
        hold(1100, 6'h2a);
        ol = 6'h00;
        frame(20'h00055, 16, st(3'b111, 6'h2a));
        frame(20'h00054, 16, st(3'b000, 6'h2a));
        ot = 1;
        hold(20, 6'h00);
        ot = 0;
        hold(20, 6'h00);
        frame(20'h00055, 16, st(3'b000, 6'h00));
        hold(1, 6'h2a);
        stby_b = 0;
        hold(20, 6'h00);
        `CHK("tristate", 6'h3f, tri_s)
        stby_b = 1;
        hold(20, 6'h00);
        `CHK("ocs", 1'b1, ocs_en)
        summarize();
    end
endmodule // testbench
